// ==== fpl_pkg.sv ====
// Summary of operation
// - memory holds 256 bytes at addresses 00 through ff, eight-bit address
// - a write replaces the stored byte; a read leaves it unchanged
// - in load mode the clear key sets the load pointer to 00
// - in load mode input key stores switches at pointer, shows them, pointer+1
// - in load mode step key shows byte at pointer, memory unchanged, pointer+1
// - operator selects run, presses clear then start; program runs from 00
// - in run mode clear halts; input ignored while halted; start restarts from 00
// - memory keeps its contents across clear, stop and start
// - running processor fetches bytes in turn and executes each one
// - display shows upper digit from bits 7..4, lower from bits 3..0
// - each switch gives one data bit, up reads one, down reads zero
package fpl_pkg;

  // =========================================================
  // timing
  localparam int CLK_KHZ     = 20000;              // 20 mhz clock
  localparam int DEB_TIME_MS = 10;                 // key debounce time
  localparam int DEB_CYCLES  = DEB_TIME_MS * CLK_KHZ;
  localparam int CNT_W       = 20;

  // =========================================================
  // register map, byte addresses
  localparam logic [11:0] REG_STATUS_OFS   = 12'h000;
  localparam logic [11:0] REG_DEBOUNCE_OFS = 12'h004;
  localparam logic [11:0] REG_MEMPTR_OFS   = 12'h008;
  localparam int          STAT_DISP_LSB    = 0;
  localparam int          STAT_PTR_LSB     = 8;
  localparam int          STAT_PC_LSB      = 16;
  localparam int          STAT_RUN_BIT     = 24;
  localparam int          STAT_EXT_BIT     = 25;
  localparam int          STAT_LOAD_BIT    = 26;
  localparam logic [7:0]  PTR_RESET        = 8'h00;

  // =========================================================
  // key indices
  localparam int KEY_CLR  = 0;
  localparam int KEY_IN   = 1;
  localparam int KEY_STEP = 2;

  // =========================================================
  // processor opcodes (upper nibble)
  localparam logic [3:0] OP_NOP   = 4'h0;
  localparam logic [3:0] OP_LDI   = 4'h1;
  localparam logic [3:0] OP_ADDI  = 4'h2;
  localparam logic [3:0] OP_BR    = 4'h3;
  localparam logic [3:0] OP_BNI   = 4'h4;
  localparam logic [3:0] OP_OUT   = 4'h5;
  localparam logic [3:0] OP_CLRIN = 4'h6;
  localparam logic [3:0] OP_HALT  = 4'hf;

  typedef enum logic [1:0] {
    CPU_HALT  = 2'b00,
    CPU_FETCH = 2'b01,
    CPU_IMM   = 2'b11
  } fpl_cpu_t;

  // whole state of the front panel except the memory
  typedef struct packed {
    logic [7:0]            ptr;
    logic [7:0]            disp;
    logic [7:0]            pc;
    logic [7:0]            acc;
    logic [3:0]            op;
    fpl_cpu_t              cpu;
    logic                  ext_flag;
    logic [2:0][CNT_W-1:0] cnt;
    logic [2:0]            key_stable;
    logic [2:0]            key_prev;
    logic [CNT_W-1:0]      deb;
    logic [31:0]           prdata;
  } fpl_state_t;

endpackage : fpl_pkg

// ==== fpl_panel.sv ====
module fpl_panel
  import fpl_pkg::*;
#(
  parameter int DEB_DEFAULT = DEB_CYCLES
)
(
  input  wire logic        pclk,             // system clock
  input  wire logic        presetn,          // async reset, active low
  input  wire logic [11:0] paddr,            // apb address
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb enable
  input  wire logic        pwrite,           // apb direction
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error
  input  wire logic        load_mode_switch, // 1 = load, 0 = run
  input  wire logic        clear_key,        // pressed high
  input  wire logic        input_key,        // pressed high
  input  wire logic        step_start_key,   // pressed high
  input  wire logic [7:0]  byte_switches,    // up = 1
  output logic      [3:0]  disp_hi,          // upper hex digit
  output logic      [3:0]  disp_lo,          // lower hex digit
  output logic             run_lamp          // processor running
);

  // =========================================================
  // storage
  logic [7:0]       mem [0:255];
  fpl_state_t       cur;
  fpl_state_t       nxt;
  logic [2:0]       key_raw;
  logic [2:0]       key_pulse;
  logic [7:0]       mem_at_ptr;
  logic [7:0]       mem_at_pc;
  logic             mem_we;
  logic             acc_ph;
  logic             map_hit;
  logic [CNT_W-1:0] deb_lim;
  // one-cycle key actions after priority
  logic             do_clr;
  logic             do_in;
  logic             do_step;

  // =========================================================
  // combinational helpers
  assign key_raw    = {step_start_key, input_key, clear_key};
  // a press acts once: stable level up while the last copy is still down
  assign key_pulse  = cur.key_stable & ~cur.key_prev;
  // same-cycle presses: clear beats input, input beats step
  assign do_clr     = key_pulse[KEY_CLR];
  assign do_in      = key_pulse[KEY_IN] & ~do_clr;
  assign do_step    = key_pulse[KEY_STEP] & ~do_clr & ~key_pulse[KEY_IN];
  assign mem_at_ptr = mem[cur.ptr];
  assign mem_at_pc  = mem[cur.pc];
  assign mem_we     = load_mode_switch & do_in;
  assign acc_ph     = psel & penable;
  assign map_hit    = (paddr == REG_STATUS_OFS) | (paddr == REG_DEBOUNCE_OFS)
                    | (paddr == REG_MEMPTR_OFS);
  assign deb_lim    = (cur.deb == '0) ? CNT_W'(1) : cur.deb;

  // outputs
  assign pready   = 1'b1;
  assign pslverr  = acc_ph & ~map_hit;
  assign prdata   = cur.prdata;
  assign disp_hi  = cur.disp[7:4];
  assign disp_lo  = cur.disp[3:0];
  assign run_lamp = (cur.cpu != CPU_HALT);

  // =========================================================
  // next state
  always_comb
  begin
    nxt          = cur;
    nxt.key_prev = cur.key_stable;
    // debounce each key
    for (int k = 0; k < 3; k++)
    begin
      if (key_raw[k] == cur.key_stable[k])
        nxt.cnt[k] = '0;
      else if (cur.cnt[k] + CNT_W'(1) >= deb_lim)
      begin
        nxt.key_stable[k] = key_raw[k];
        nxt.cnt[k]        = '0;
      end
      else
        nxt.cnt[k] = cur.cnt[k] + CNT_W'(1);
    end

    // processor stepping
    case (cur.cpu)
      CPU_FETCH:
      begin
        nxt.op = mem_at_pc[7:4];
        nxt.pc = cur.pc + 8'h01;
        case (mem_at_pc[7:4])
          OP_LDI, OP_ADDI, OP_BR, OP_BNI: nxt.cpu = CPU_IMM;
          OP_OUT:   nxt.disp     = cur.acc;
          OP_CLRIN: nxt.ext_flag = 1'b0;
          OP_HALT:  nxt.cpu      = CPU_HALT;
          default:  nxt.cpu      = CPU_FETCH;
        endcase
      end
      CPU_IMM:
      begin
        nxt.cpu = CPU_FETCH;
        nxt.pc  = cur.pc + 8'h01;
        case (cur.op)
          OP_LDI:  nxt.acc = mem_at_pc;
          OP_ADDI: nxt.acc = cur.acc + mem_at_pc;
          OP_BR:   nxt.pc  = mem_at_pc;
          OP_BNI:
          begin
            if (!cur.ext_flag)
              nxt.pc = mem_at_pc;
          end
          default: nxt.acc = cur.acc;
        endcase
      end
      default: nxt.cpu = CPU_HALT;
    endcase

    // front panel keys override the processor
    if (load_mode_switch)
    begin
      nxt.cpu = CPU_HALT;
      if (do_clr)
        nxt.ptr = PTR_RESET;
      else if (do_in)
      begin
        nxt.disp = byte_switches;
        nxt.ptr  = cur.ptr + 8'h01;
      end
      // examine: show the stored byte, memory left alone
      else if (do_step)
      begin
        nxt.disp = mem_at_ptr;
        nxt.ptr  = cur.ptr + 8'h01;
      end
    end
    else
    begin
      if (do_clr)
      begin
        nxt.cpu      = CPU_HALT;
        nxt.pc       = PTR_RESET;
        nxt.ext_flag = 1'b0;
      end
      // start always begins at the first location with a clean slate
      else if (do_step)
      begin
        nxt.cpu      = CPU_FETCH;
        nxt.pc       = PTR_RESET;
        nxt.acc      = 8'h00;
        nxt.ext_flag = 1'b0;
      end
      else if (do_in && cur.cpu != CPU_HALT)
        nxt.ext_flag = 1'b1;
    end

    // apb read data captured in setup phase
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        REG_STATUS_OFS:
        begin
          nxt.prdata                          = 32'h0000_0000;
          // unused bits stay zero
          nxt.prdata[STAT_DISP_LSB +: 8]      = cur.disp;
          nxt.prdata[STAT_PTR_LSB +: 8]       = cur.ptr;
          nxt.prdata[STAT_PC_LSB +: 8]        = cur.pc;
          nxt.prdata[STAT_RUN_BIT]            = (cur.cpu != CPU_HALT);
          nxt.prdata[STAT_EXT_BIT]            = cur.ext_flag;
          nxt.prdata[STAT_LOAD_BIT]           = load_mode_switch;
        end
        REG_DEBOUNCE_OFS: nxt.prdata = {{(32-CNT_W){1'b0}}, cur.deb};
        REG_MEMPTR_OFS:   nxt.prdata = {24'h00_0000, mem_at_ptr};
        default:          nxt.prdata = 32'h0000_0000;
      endcase
    end
    // apb write of the debounce length
    if (acc_ph && pwrite && paddr == REG_DEBOUNCE_OFS)
      nxt.deb = pwdata[CNT_W-1:0];
  end

  // =========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur     <= '0;
      cur.cpu <= CPU_HALT;
      cur.deb <= CNT_W'(DEB_DEFAULT);
    end
    else
      cur <= nxt;
  end

  // memory, written only by a load key press, never reset
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[cur.ptr] <= byte_switches;
  end

  // =========================================================
  // assertions
  // each property looks one edge past the action that it guards, a_clear_halt two edges for the input flag
  // memory never written is unknown, so the checks that memory stays unchanged use case equality; a_step_show and a_fetch_advance use ==

  // clear in load mode returns the pointer to the first location
  a_clear_ptr_zero : assert property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch && do_clr |=> cur.ptr == 8'h00)
    else $error("load pointer not cleared");

  // input key stores and shows the switch byte, then moves on
  a_input_store : assert property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch && do_in |=> cur.disp == $past(byte_switches)
      && cur.ptr == $past(cur.ptr) + 8'h01
      && mem[$past(cur.ptr)] == $past(byte_switches))
    else $error("input key store wrong");

  // the digits on the pins follow the switch byte after a load
  a_switch_bits : assert property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch && do_in |=> {disp_hi, disp_lo} == $past(byte_switches))
    else $error("display digits differ from switches");

  // step key shows the stored byte and moves on
  a_step_show : assert property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch && do_step |=> cur.disp == $past(mem_at_ptr)
      && cur.ptr == $past(cur.ptr) + 8'h01)
    else $error("step key examine wrong");

  // examining leaves the location untouched
  a_step_mem_keep : assert property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch && do_step |=> mem[$past(cur.ptr)] === $past(mem_at_ptr))
    else $error("step key altered memory");

  // start in run mode begins at address 00
  a_run_start : assert property (@(posedge pclk) disable iff (!presetn)
    !load_mode_switch && do_step |=> cur.cpu == CPU_FETCH && cur.pc == 8'h00)
    else $error("start did not begin at 00");

  // start clears the accumulator and the input flag
  a_start_fresh : assert property (@(posedge pclk) disable iff (!presetn)
    !load_mode_switch && do_step |=> cur.acc == 8'h00 && !cur.ext_flag)
    else $error("start left old state");

  // load mode keeps the processor stopped
  a_load_halts : assert property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch |=> cur.cpu == CPU_HALT)
    else $error("processor ran in load mode");

  // clear stops the program and drops the input flag
  a_clear_halt : assert property (@(posedge pclk) disable iff (!presetn)
    !load_mode_switch && do_clr |=> cur.cpu == CPU_HALT ##1 !cur.ext_flag)
    else $error("clear did not halt");

  // a stopped processor stays stopped until a start in run mode
  a_halt_stays : assert property (@(posedge pclk) disable iff (!presetn)
    cur.cpu == CPU_HALT && (load_mode_switch || !do_step) |=> cur.cpu == CPU_HALT)
    else $error("processor left halt without start");

  // in run mode input is ignored while halted
  a_halt_ignore : assert property (@(posedge pclk) disable iff (!presetn)
    cur.cpu == CPU_HALT && !cur.ext_flag |=> !cur.ext_flag)
    else $error("input acted while halted");

  // memory only changes through a load
  a_mem_hold : assert property (@(posedge pclk) disable iff (!presetn)
    !mem_we |=> mem[$past(cur.ptr)] === $past(mem_at_ptr))
    else $error("memory changed without load");

  // fetch steps the program counter and latches the opcode
  a_fetch_advance : assert property (@(posedge pclk) disable iff (!presetn)
    cur.cpu == CPU_FETCH && !load_mode_switch && !do_clr && !do_step
      |=> cur.pc == $past(cur.pc) + 8'h01 && cur.op == $past(mem_at_pc[7:4]))
    else $error("fetch did not advance");

  // an immediate byte always returns to fetch
  a_imm_return : assert property (@(posedge pclk) disable iff (!presetn)
    cur.cpu == CPU_IMM && !load_mode_switch && !do_clr && !do_step
      |=> cur.cpu == CPU_FETCH)
    else $error("immediate cycle did not return to fetch");

  // a running program sees each input press as a flag
  a_ext_flag_set : assert property (@(posedge pclk) disable iff (!presetn)
    !load_mode_switch && do_in && cur.cpu != CPU_HALT |=> cur.ext_flag)
    else $error("input flag not raised");

  // input in run mode never writes memory nor moves the pointer
  a_run_no_store : assert property (@(posedge pclk) disable iff (!presetn)
    !load_mode_switch && do_in |=> mem[$past(cur.ptr)] === $past(mem_at_ptr)
      && cur.ptr == $past(cur.ptr))
    else $error("input key wrote memory in run mode");

  // main scenarios: load, examine, run, input flag
  c_load_store : cover property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch && do_in ##[1:50] load_mode_switch && do_in);
  c_examine : cover property (@(posedge pclk) disable iff (!presetn)
    load_mode_switch && do_clr ##[1:50] load_mode_switch && do_step);
  c_run : cover property (@(posedge pclk) disable iff (!presetn)
    !load_mode_switch && do_step ##[1:50] cur.cpu == CPU_IMM);
  c_ext_in : cover property (@(posedge pclk) disable iff (!presetn)
    cur.ext_flag ##[1:50] !cur.ext_flag && cur.cpu != CPU_HALT);

endmodule : fpl_panel

// ==== fpl_operator.sv ====
// =====
// operator at the panel: mode switch, three keys, byte switches
module fpl_operator
  import fpl_pkg::*;
(
  input  wire logic       pclk,             // system clock
  output logic            load_mode_switch, // 1 = load, 0 = run
  output logic      [2:0] keys,             // clear, input, step/start
  output logic      [7:0] byte_switches     // up = 1
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle panel at power up
  initial
  begin
    load_mode_switch = 1'b1;
    keys = 3'h0;
    byte_switches = 8'h00;
  end

  // switches set with the press, key held then released long enough
  task automatic press(input int idx, input logic [7:0] sw);
    @(posedge pclk);
    byte_switches <= sw;
    keys[idx] <= 1'b1;
    repeat (6) @(posedge pclk);
    keys[idx] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : press

  // flip the load/run selector, let it settle
  task automatic set_mode(input logic m);
    @(posedge pclk);
    load_mode_switch <= m;
    repeat (2) @(posedge pclk);
  endtask : set_mode
endmodule : fpl_operator

// ==== fpl_panel_tb_top.sv ====
module fpl_panel_tb_top
  import fpl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run_lamp, mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  disp_hi, disp_lo;
  logic [2:0]  keys;
  logic [7:0]  sw, b;
  logic        er;
  logic [7:0]  mem_q [256];
  logic [7:0]  prog [11] = '{8'h10, 8'h00, 8'h50, 8'h40, 8'h03, 8'h60, 8'h20, 8'h01,
                             8'h50, 8'h30, 8'h03};
  int          errors, samples_checked;

  fpl_panel #(.DEB_DEFAULT(2)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .load_mode_switch(mode),
    .clear_key(keys[KEY_CLR]), .input_key(keys[KEY_IN]), .step_start_key(keys[KEY_STEP]),
    .byte_switches(sw), .disp_hi(disp_hi), .disp_lo(disp_lo), .run_lamp(run_lamp));

  fpl_operator op (.pclk(pclk), .load_mode_switch(mode), .keys(keys), .byte_switches(sw));

  // =====
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // examine every location from the pointer at 00
  task automatic step_all();
    for (int i = 0; i < 256; i++)
    begin
      op.press(KEY_STEP, 8'($urandom));
      chk({disp_hi, disp_lo}, mem_q[i]);
    end
  endtask : step_all

  task automatic report_and_stop();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // =====
  // clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    errors++;
    report_and_stop();
  end

  // =====
  // main sequence
  initial
  begin
    void'($urandom(32'h9d7b85cb));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({run_lamp, disp_hi, disp_lo}, 32'h0);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rd, 32'h0400_0000);
    apb(1'b1, REG_DEBOUNCE_OFS, 32'h3);
    apb(1'b0, REG_DEBOUNCE_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(er, 1'b1);
    // fill all 256 locations with random bytes
    op.press(KEY_CLR, 8'h00);
    for (int i = 0; i < 256; i++)
    begin
      b = 8'($urandom);
      mem_q[i] = b;
      op.press(KEY_IN, b);
      chk({disp_hi, disp_lo}, b);
    end
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rd[15:8], 32'h0);
    chk(er, 1'b0);
    // byte at the load pointer, read without disturbing it
    apb(1'b0, REG_MEMPTR_OFS, 32'h0);
    chk(rd, {24'h00_0000, mem_q[0]});
    for (int i = 0; i < 5; i++)
      op.press(KEY_STEP, 8'h00);
    op.press(KEY_CLR, 8'h00);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rd[15:8], 32'h0);
    step_all();
    // overwrite the start with a counter program
    op.press(KEY_CLR, 8'h00);
    for (int i = 0; i < 11; i++)
    begin
      mem_q[i] = prog[i];
      op.press(KEY_IN, prog[i]);
    end
    op.set_mode(1'b0);
    op.press(KEY_CLR, 8'h00);
    op.press(KEY_STEP, 8'h00);
    chk({run_lamp, disp_hi, disp_lo}, 32'h100);
    for (int k = 1; k < 4; k++)
    begin
      op.press(KEY_IN, 8'($urandom));
      chk({disp_hi, disp_lo}, k);
    end
    op.press(KEY_CLR, 8'h00);
    op.press(KEY_IN, 8'h00);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rd[25:24], 32'h0);
    op.press(KEY_STEP, 8'h00);
    chk({run_lamp, disp_hi, disp_lo}, 32'h100);
    op.press(KEY_IN, 8'h00);
    chk({disp_hi, disp_lo}, 32'h1);
    // a program whose first byte halts the processor
    op.set_mode(1'b1);
    op.press(KEY_CLR, 8'h00);
    mem_q[0] = {OP_HALT, 4'h0};
    op.press(KEY_IN, {OP_HALT, 4'h0});
    op.set_mode(1'b0);
    op.press(KEY_CLR, 8'h00);
    op.press(KEY_STEP, 8'h00);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rd[24:16], 32'h001);
    chk({run_lamp, disp_hi, disp_lo}, 32'h0f0);
    // back to load mode: memory must be intact
    op.set_mode(1'b1);
    op.press(KEY_CLR, 8'h00);
    step_all();
    report_and_stop();
  end
endmodule : fpl_panel_tb_top
